// ===== logic/wkt_regs.svh
// Purpose: Constants of the wake-up timing and rate check block
// Assumes: 40 MHz clk, synchronous active-low reset
// Notes:   Field positions index the stored register words
`ifndef WKT_REGS_SVH
`define WKT_REGS_SVH
// ****************************************************
// Register layout and reset values
// ****************************************************
`define WKT_WUC_RESET   32'h7F8BE110
`define WKT_WUR_RESET   18'h107E8
`define WKT_WUE_BIT     31
`define WKT_PSEL_HI     21
`define WKT_PSEL_LO     20
`define WKT_WCNT_HI     19
`define WKT_WCNT_LO     13
`define WKT_WL1_X16     12
`define WKT_WL1N_HI     11
`define WKT_WL1N_LO     6
`define WKT_WL2_HI      5
`define WKT_WL2_LO      3
`define WKT_POL_HI      17
`define WKT_POL_LO      16
`define WKT_CHK_BIT     15
`define WKT_RATE_HI     14
`define WKT_RATE_LO     5
`define WKT_TOL_HI      4
`define WKT_TOL_LO      0
// ****************************************************
// Timing
// ****************************************************
`define WKT_CLK_NS      25
`define WKT_TICK_MS     1
`define WKT_MS_CYCLES   ((`WKT_TICK_MS * 1000000) / `WKT_CLK_NS)
`define WKT_SLOW_MS     10
`define WKT_UNIT_NS     1560
`define WKT_UNIT_CYCLES (`WKT_UNIT_NS / `WKT_CLK_NS)
`define WKT_PRE_MID     16
`define WKT_PRE_HI      256
`define WKT_MUL5        8
`define WKT_MUL6        16
`define WKT_MUL7        31
`endif

// ===== logic/wkt_pkg.sv
// Purpose: Types of the wake-up timing and rate check block
// Assumes: Nothing
// Notes:   One packed struct per module holds all its state
package wkt_pkg;
   typedef enum logic [2:0] {S_OFF, S_PERIOD, S_DELAY1, S_DELAY2, S_HEADER, S_MSG} wkt_state_t;
   typedef enum logic [1:0] {R_IDLE, R_FIRST, R_MEAS} wkt_rstate_t;
   typedef struct packed {
      wkt_state_t  state;
      logic [31:0] wake_control_register;
      logic [17:0] wake_rate_check_config;
      logic [14:0] cnt;
      logic        osc;
      logic        signal_strength_check;
      logic        test2;
      logic        rstart;
      logic        acc;
      logic        rej;
      logic        alert_act;
      logic        pin_out;
      logic        pin_oe;
   } wkt_main_t;
   typedef struct packed {
      wkt_rstate_t state;
      logic        last_rx;
      logic [10:0] meas;
      logic        done;
      logic        pass;
   } wkt_rate_t;
   typedef struct packed {
      logic [15:0] ms_cnt;
      logic [3:0]  dec_cnt;
      logic [5:0]  unit_cnt;
      logic        ms;
      logic        slow;
      logic        unit;
   } wkt_tick_t;
endpackage : wkt_pkg

// ===== logic/wkt_tick_if.sv
// Purpose: Tick enables shared between the block's modules
// Assumes: All ticks are one-cycle pulses on clk
// Notes:   gen drives, sink reads
`timescale 1ns/1ps
interface wkt_tick_if;
   logic ms_tick;
   logic slow_tick;
   logic unit_tick;
   modport gen (output ms_tick, output slow_tick, output unit_tick);
   modport sink (input ms_tick, input slow_tick, input unit_tick);
endinterface : wkt_tick_if

// ===== logic/wkt_tick_gen.sv
// Purpose: 1 ms, 10 ms and rate unit tick enables
// Assumes: MS_CYC below 65536
// Notes:   Stands in for the RC and reference dividers
`timescale 1ns/1ps
`include "wkt_regs.svh"
module wkt_tick_gen #(
   parameter int MS_CYC = `WKT_MS_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   wkt_tick_if.gen  tk
);
   import wkt_pkg::*;
   wkt_tick_t st;
   wkt_tick_t next_st;

   always_comb begin
      next_st = st;
      next_st.ms = 1'b0;
      next_st.slow = 1'b0;
      next_st.unit = 1'b0;
      if (st.ms_cnt == 16'(MS_CYC - 1)) begin
         next_st.ms_cnt = '0;
         next_st.ms = 1'b1;
         if (st.dec_cnt == 4'(`WKT_SLOW_MS - 1)) begin
            next_st.dec_cnt = '0;
            next_st.slow = 1'b1;
         end else begin
            next_st.dec_cnt = st.dec_cnt + 4'h1;
         end
      end else begin
         next_st.ms_cnt = st.ms_cnt + 16'h1;
      end
      if (st.unit_cnt == 6'(`WKT_UNIT_CYCLES - 1)) begin
         next_st.unit_cnt = '0;
         next_st.unit = 1'b1;
      end else begin
         next_st.unit_cnt = st.unit_cnt + 6'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tk.ms_tick = st.ms;
   assign tk.slow_tick = st.slow;
   assign tk.unit_tick = st.unit;

   slow_on_ms_a: assert property (@(posedge clk) disable iff (!rstn)
      st.slow |-> st.ms && $past(st.dec_cnt) == 4'(`WKT_SLOW_MS - 1))
      else $error("slow tick off the ms grid");
   unit_step_a: assert property (@(posedge clk) disable iff (!rstn)
      st.unit |-> $past(st.unit_cnt) == 6'(`WKT_UNIT_CYCLES - 1) ##1 !st.unit [*8])
      else $error("unit tick spacing wrong");
endmodule : wkt_tick_gen

// ===== logic/wkt_rate_chk.sv
// Purpose: Header bit period measurement and tolerance check
// Assumes: Header alternates, so edge spacing is one bit
// Notes:   Saturated count ends the measurement as a failure
`timescale 1ns/1ps
`include "wkt_regs.svh"
module wkt_rate_chk (
   input  wire logic clk,
   input  wire logic rstn,
   wkt_tick_if.sink  tk,
   input  wire logic start,
   input  wire logic rx_data,
   input  wire logic [9:0] rate,
   input  wire logic [4:0] tol,
   input  wire logic chk_en,
   output logic      done,
   output logic      pass
);
   import wkt_pkg::*;
   wkt_rate_t   st;
   wkt_rate_t   next_st;
   logic [10:0] tgt;
   logic [10:0] diff;
   logic        edge_seen;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.last_rx = rx_data;
      edge_seen = rx_data ^ st.last_rx;
      tgt = {1'b0, rate} + 11'h1;
      diff = (st.meas >= tgt) ? st.meas - tgt : tgt - st.meas;
      unique case (st.state)
         R_IDLE: if (start) begin
            next_st.meas = '0;
            if (!chk_en) begin
               next_st.done = 1'b1;
               next_st.pass = 1'b1;
            end else begin
               next_st.state = R_FIRST;
            end
         end
         R_FIRST, R_MEAS: if (edge_seen && st.state == R_FIRST) begin
            next_st.state = R_MEAS;
            next_st.meas = '0;
         end else if (edge_seen) begin
            next_st.done = 1'b1;
            next_st.pass = (diff <= {6'h0, tol});
            next_st.state = R_IDLE;
         end else if (tk.unit_tick) begin
            if (st.meas == 11'h7FF) begin
               next_st.done = 1'b1;
               next_st.pass = 1'b0;
               next_st.state = R_IDLE;
            end else begin
               next_st.meas = st.meas + 11'h1;
            end
         end
         default: next_st.state = R_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '{state: R_IDLE, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
   assign pass = st.pass;

   rate_window_a: assert property (@(posedge clk) disable iff (!rstn)
      st.done && $past(st.state) == R_MEAS && $past(st.meas) != 11'h7FF |->
      st.pass == ((int'($past(st.meas)) - int'($past(rate)) - 1 <= int'($past(tol)))
               && (int'($past(rate)) + 1 - int'($past(st.meas)) <= int'($past(tol)))))
      else $error("rate verdict wrong");
   no_check_a: assert property (@(posedge clk) disable iff (!rstn)
      st.state == R_IDLE && start && !chk_en |=> st.done && st.pass)
      else $error("unchecked header not passed");
endmodule : wkt_rate_chk

// ===== logic/wkt_top.sv
// Purpose: Wake-up period, test delays, rate check, alert pin
// Assumes: Register words written through wuc_wr and wur_wr
// Notes:   Framing and address matching sit outside
`timescale 1ns/1ps
`include "wkt_regs.svh"
module wkt_top #(
   parameter int MS_CYC = `WKT_MS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        wuc_wr,
   input  wire logic        wur_wr,
   input  wire logic [31:0] cfg_wdata,
   input  wire logic        rx_data,
   input  wire logic        strength_ok,
   input  wire logic        msg_valid,
   input  wire logic        msg_fail,
   input  wire logic        alert_ack,
   output logic             osc_run,
   output logic             strength_check,
   output logic             header_check,
   output logic             header_accept,
   output logic             header_reject,
   output logic             alert_pin_out,
   output logic             alert_pin_oe,
   output logic [31:0]      wuc_rdata,
   output logic [17:0]      wur_rdata,
   output wkt_pkg::wkt_state_t wake_state
);
   import wkt_pkg::*;

   // ****************************************************
   // State and derived counts
   // ****************************************************
   wkt_main_t   st;
   wkt_main_t   next_st;
   logic [8:0]  wake_period_field;
   logic [6:0]  wl1;
   logic [2:0]  wl2;
   logic [14:0] per_tgt;
   logic [10:0] wl1_ticks;
   logic [4:0]  mul;
   logic [14:0] wl2_tgt;
   logic        alert_set;
   logic        rate_done;
   logic        rate_pass;

   localparam wkt_main_t RST = '{
      state:  S_OFF,
      wake_control_register:    `WKT_WUC_RESET,
      wake_rate_check_config:    `WKT_WUR_RESET,
      pin_oe: 1'b1,
      default: '0
   };

   wkt_tick_if tk ();

   wkt_tick_gen #(
      .MS_CYC (MS_CYC)
   ) u_tick (
      .clk  (clk),
      .rstn (rstn),
      .tk   (tk.gen)
   );

   wkt_rate_chk u_rate (
      .clk     (clk),
      .rstn    (rstn),
      .tk      (tk.sink),
      .start   (st.rstart),
      .rx_data (rx_data),
      .rate    (st.wake_rate_check_config[`WKT_RATE_HI:`WKT_RATE_LO]),
      .tol     (st.wake_rate_check_config[`WKT_TOL_HI:`WKT_TOL_LO]),
      .chk_en  (st.wake_rate_check_config[`WKT_CHK_BIT]),
      .done    (rate_done),
      .pass    (rate_pass)
   );

   always_comb begin
      wake_period_field = st.wake_control_register[`WKT_PSEL_HI:`WKT_WCNT_LO];
      wl1 = st.wake_control_register[`WKT_WL1_X16:`WKT_WL1N_LO];
      wl2 = st.wake_control_register[`WKT_WL2_HI:`WKT_WL2_LO];
      unique case (wake_period_field[8:7])
         2'b00: per_tgt = 15'(wake_period_field[6:0]) + 15'h1;
         2'b11: per_tgt = 15'(`WKT_PRE_HI) * 15'(wake_period_field[6:0]) + 15'h1;
         default: per_tgt = 15'(`WKT_PRE_MID) * 15'(wake_period_field[6:0]) + 15'h1;
      endcase
      wl1_ticks = (wl1[6] ? 11'(`WKT_PRE_MID) : 11'h1)
                * (11'(wl1[5:0]) + 11'h1);
      unique case (wl2)
         3'h5: mul = 5'(`WKT_MUL5);
         3'h6: mul = 5'(`WKT_MUL6);
         3'h7: mul = 5'(`WKT_MUL7);
         default: mul = 5'(wl2);
      endcase
      wl2_tgt = 15'(mul) * 15'(wl1_ticks);
   end

   // ****************************************************
   // Wake-up sequence
   // ****************************************************
   always_comb begin
      next_st = st;
      next_st.signal_strength_check = 1'b0;
      next_st.test2 = 1'b0;
      next_st.rstart = 1'b0;
      next_st.acc = 1'b0;
      next_st.rej = 1'b0;
      alert_set = 1'b0;
      unique case (st.state)
         S_OFF: begin
            next_st.osc = 1'b0;
            if (st.wake_control_register[`WKT_WUE_BIT]) begin
               next_st.state = S_PERIOD;
            end
         end
         S_PERIOD: if (tk.slow_tick) begin
            if (st.cnt + 15'h1 == per_tgt) begin
               next_st.osc = 1'b1;
               next_st.state = S_DELAY1;
            end else begin
               next_st.cnt = st.cnt + 15'h1;
            end
         end
         S_DELAY1: if (tk.ms_tick) begin
            if (st.cnt + 15'h1 == 15'(wl1_ticks)) begin
               next_st.signal_strength_check = 1'b1;
               if (!strength_ok) begin
                  next_st.osc = 1'b0;
                  next_st.state = S_PERIOD;
               end else if (wl2 == 3'h0) begin
                  next_st.test2 = 1'b1;
                  next_st.rstart = 1'b1;
                  next_st.state = S_HEADER;
               end else begin
                  next_st.state = S_DELAY2;
               end
            end else begin
               next_st.cnt = st.cnt + 15'h1;
            end
         end
         S_DELAY2: if (tk.ms_tick) begin
            if (st.cnt + 15'h1 == wl2_tgt) begin
               next_st.test2 = 1'b1;
               next_st.rstart = 1'b1;
               next_st.state = S_HEADER;
            end else begin
               next_st.cnt = st.cnt + 15'h1;
            end
         end
         S_HEADER: if (rate_done) begin
            if (rate_pass) begin
               next_st.acc = 1'b1;
               next_st.state = S_MSG;
            end else begin
               next_st.rej = 1'b1;
               next_st.osc = 1'b0;
               next_st.state = S_PERIOD;
            end
         end
         S_MSG: if (msg_valid) begin
            alert_set = 1'b1;
            next_st.wake_control_register[`WKT_WUE_BIT] = 1'b0;
            next_st.osc = 1'b0;
            next_st.state = S_OFF;
         end else if (msg_fail) begin
            next_st.osc = 1'b0;
            next_st.state = S_PERIOD;
         end
         default: next_st.state = S_OFF;
      endcase
      if (st.state != S_OFF && !st.wake_control_register[`WKT_WUE_BIT]) begin
         next_st.osc = 1'b0;
         next_st.state = S_OFF;
      end
      if (next_st.state != st.state) begin
         next_st.cnt = '0;
      end
      if (wuc_wr) begin
         next_st.wake_control_register = cfg_wdata;
      end
      if (wur_wr) begin
         next_st.wake_rate_check_config = cfg_wdata[17:0];
      end
      next_st.alert_act = (st.alert_act & ~alert_ack) | alert_set;
      if (next_st.wake_rate_check_config[`WKT_POL_HI]) begin
         next_st.pin_oe = next_st.alert_act;
         next_st.pin_out = 1'b0;
      end else begin
         next_st.pin_oe = 1'b1;
         next_st.pin_out = (next_st.alert_act == next_st.wake_rate_check_config[`WKT_POL_LO]);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= RST;
      end else begin
         st <= next_st;
      end
   end

   assign osc_run = st.osc;
   assign strength_check = st.signal_strength_check;
   assign header_check = st.test2;
   assign header_accept = st.acc;
   assign header_reject = st.rej;
   assign alert_pin_out = st.pin_out;
   assign alert_pin_oe = st.pin_oe;
   assign wuc_rdata = st.wake_control_register;
   assign wur_rdata = st.wake_rate_check_config;
   assign wake_state = st.state;

   // ****************************************************
   // Checks
   // ****************************************************
   period_x1_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(st.osc) && $past(st.wake_control_register[`WKT_PSEL_HI:`WKT_PSEL_LO]) == 2'b00 |->
      $past(st.cnt) == 15'($past(st.wake_control_register[`WKT_WCNT_HI:`WKT_WCNT_LO])))
      else $error("x1 period length wrong");
   period_x16_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(st.osc) && ^$past(st.wake_control_register[`WKT_PSEL_HI:`WKT_PSEL_LO]) |->
      $past(st.cnt) == 15'h10 * 15'($past(st.wake_control_register[`WKT_WCNT_HI:`WKT_WCNT_LO])))
      else $error("x16 period length wrong");
   period_x256_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(st.osc) && $past(st.wake_control_register[`WKT_PSEL_HI:`WKT_PSEL_LO]) == 2'b11 |->
      $past(st.cnt) == 15'h100 * 15'($past(st.wake_control_register[`WKT_WCNT_HI:`WKT_WCNT_LO])))
      else $error("x256 period length wrong");
   first_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      st.signal_strength_check |-> $past(tk.ms_tick) && $past(st.cnt) + 15'h1 ==
      ($past(st.wake_control_register[`WKT_WL1_X16]) ? 15'h10 : 15'h1)
      * (15'($past(st.wake_control_register[`WKT_WL1N_HI:`WKT_WL1N_LO])) + 15'h1))
      else $error("first test delay wrong");
   second_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      st.test2 && $past(st.state) == S_DELAY2 |-> $past(st.cnt) + 15'h1 ==
      15'($past(wl1_ticks)) * ($past(wl2) == 3'h7 ? 15'h1F : $past(wl2) == 3'h6 ? 15'h10 :
      $past(wl2) == 3'h5 ? 15'h8 : 15'($past(wl2))))
      else $error("second test delay wrong");
   same_moment_a: assert property (@(posedge clk) disable iff (!rstn)
      st.signal_strength_check && $past(wl2) == 3'h0 && $past(strength_ok) |-> st.test2 ##1 st.state == S_HEADER)
      else $error("tests not simultaneous");
   osc_first_a: assert property (@(posedge clk) disable iff (!rstn)
      st.signal_strength_check |-> $past(st.osc) && $past(st.state) == S_DELAY1)
      else $error("first test without oscillator");
   pin_drive_a: assert property (@(posedge clk) disable iff (!rstn)
      st.wake_rate_check_config[`WKT_POL_HI] ? (st.pin_oe == st.alert_act && !st.pin_out)
      : (st.pin_oe && st.pin_out == (st.alert_act == st.wake_rate_check_config[`WKT_POL_LO])))
      else $error("alert pin drive wrong");
endmodule : wkt_top

// ===== verif/wkt_host_model.sv
// Purpose: Host side watching the alert pin
// Assumes: Pull-up on the pin line
// Notes:   Acks an active alert while ack_en is high
`timescale 1ns/1ps
module wkt_host_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       pin_out,
   input  wire logic       pin_oe,
   input  wire logic [1:0] pol,
   input  wire logic       ack_en,
   output logic            pin_level,
   output logic            seen,
   output logic            ack
);
   // ****
   // Pin level and alert detect
   // ****
   // Released line floats to the pull-up level
   assign pin_level = pin_oe ? pin_out : 1'b1;
   assign seen      = (pol == 2'b01) ? pin_level : ~pin_level;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack <= 1'b0;
      end else begin
         ack <= seen & ack_en & ~ack;
      end
   end
endmodule : wkt_host_model

// ===== verif/alert_output_pin_timing_rate_check_bench.sv
// Purpose: Self-checking bench of the wake-up timing block
// Assumes: MS_CYC shortened to 4 cycles
// Notes:   First tick of each count may be partial
`timescale 1ns/1ps
`include "wkt_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module alert_output_pin_timing_rate_check_bench;
   import wkt_pkg::*;
   localparam int MSC  = 4;
   localparam int SLOW = `WKT_SLOW_MS * MSC;
   localparam int UNIT = `WKT_UNIT_NS / `WKT_CLK_NS;
   logic        clk, rstn, wuc_wr, wur_wr, rx_data, strength_ok;
   logic        msg_valid, msg_fail, ack_en, ack, seen, pin_level;
   logic        osc_run, strength_check, header_check, header_accept, header_reject;
   logic        alert_pin_out, alert_pin_oe;
   logic [31:0] cfg_wdata, wuc_rdata;
   logic [17:0] wur_rdata;
   wkt_state_t  wake_state;
   int          compares, n_mismatch, n;
   wkt_top #(.MS_CYC(MSC)) u_wkt_top (.clk(clk), .rstn(rstn), .wuc_wr(wuc_wr),
      .wur_wr(wur_wr), .cfg_wdata(cfg_wdata), .rx_data(rx_data),
      .strength_ok(strength_ok), .msg_valid(msg_valid), .msg_fail(msg_fail),
      .alert_ack(ack), .osc_run(osc_run), .strength_check(strength_check),
      .header_check(header_check), .header_accept(header_accept),
      .header_reject(header_reject), .alert_pin_out(alert_pin_out),
      .alert_pin_oe(alert_pin_oe), .wuc_rdata(wuc_rdata), .wur_rdata(wur_rdata),
      .wake_state(wake_state));
   wkt_host_model u_wkt_host_model (.clk(clk), .rstn(rstn), .pin_out(alert_pin_out),
      .pin_oe(alert_pin_oe), .pol(wur_rdata[17:16]), .ack_en(ack_en),
      .pin_level(pin_level), .seen(seen), .ack(ack));
   // ****
   // Clock, closing and watchdog
   // ****
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic end_sim();
      $display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end
   // ****
   // Access and timing tasks
   // ****
   task automatic wr(input bit sel_wur, input logic [31:0] v);
      @(posedge clk);
      wuc_wr    <= ~sel_wur;
      wur_wr    <= sel_wur;
      cfg_wdata <= v;
      @(posedge clk);
      wuc_wr <= 1'b0;
      wur_wr <= 1'b0;
      #1;
      if (sel_wur) `CHK(wur_rdata, v[17:0])
      else `CHK(wuc_rdata, v)
   endtask : wr
   task automatic wait_on(input int sel, output int cnt);
      bit hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < 12000) begin
         @(posedge clk);
         #1;
         cnt++;
         case (sel)
            0: hit = (osc_run === 1'b1);
            1: hit = (strength_check === 1'b1);
            2: hit = (header_check === 1'b1);
            default: hit = (header_accept === 1'b1) || (header_reject === 1'b1);
         endcase
      end
      if (!hit) begin
         n_mismatch++;
         $display("Error at %0t: wait timed out", $time);
      end
   endtask : wait_on
   task automatic span(input int cnt, input int t, input int p);
      `CHK((cnt > (t - 1) * p) && (cnt <= t * p + 4), 1'b1)
   endtask : span
   task automatic run(input logic [1:0] ps, input logic [6:0] c, input logic [6:0] w1,
                      input logic [2:0] w2, input bit sok);
      int tp;
      int t1;
      int mul[8] = '{0, 1, 2, 3, 4, 8, 16, 31};
      tp = (ps == 2'b00) ? int'(c) + 1 : (ps == 2'b11) ? 256 * c + 1 : 16 * c + 1;
      t1 = (w1[6] ? 16 : 1) * (int'(w1[5:0]) + 1);
      @(posedge clk);
      strength_ok <= sok;
      wr(1'b0, {1'b1, 9'h1FE, ps, c, w1, w2, 3'b000});
      wait_on(0, n);
      span(n, tp, SLOW);
      wait_on(1, n);
      span(n, t1, MSC);
      if (!sok) begin
         @(posedge clk);
         #1;
         `CHK(osc_run, 1'b0)
         `CHK(wake_state, S_PERIOD)
      end else if (w2 == 3'b000) begin
         `CHK(header_check, 1'b1)
      end else begin
         wait_on(2, n);
         span(n, mul[w2] * t1, MSC);
      end
   endtask : run
   task automatic acc_off();
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK(header_accept, 1'b1)
   endtask : acc_off
   task automatic stop();
      wr(1'b0, 32'h7F8BE110);
      @(posedge clk);
      #1;
      `CHK(wake_state, S_OFF)
   endtask : stop
   // ****
   // Tests
   // ****
   int rt[4][4] = '{'{9, 2, 10, 1}, '{9, 2, 15, 0}, '{9, 31, 40, 1}, '{9, 31, 43, 0}};
   initial begin
      rstn        = 1'b0;
      wuc_wr      = 1'b0;
      wur_wr      = 1'b0;
      cfg_wdata   = 32'h00000000;
      rx_data     = 1'b0;
      strength_ok = 1'b1;
      msg_valid   = 1'b0;
      msg_fail    = 1'b0;
      ack_en      = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(wuc_rdata, 32'h7F8BE110)
      `CHK(wur_rdata, 18'h107E8)
      `CHK({alert_pin_oe, alert_pin_out}, 2'b10)
      `CHK(wake_state, S_OFF)
      @(posedge clk);
      rstn <= 1'b1;
      $display("Test reset done");
      for (int ps = 0; ps < 4; ps++) begin
         run(ps[1:0], 7'h01, 7'h00, 3'b000, 1'b1);
         acc_off();
         stop();
      end
      $display("Test period done");
      foreach (rt[i]) begin
         run(2'b00, 7'h00, (i == 0) ? 7'h3F : 7'h41, 3'b001, 1'b1);
         acc_off();
         stop();
      end
      $display("Test first delay done");
      for (int k = 0; k < 8; k++) begin
         run(2'b00, 7'h00, 7'h00, k[2:0], 1'b1);
         acc_off();
         stop();
      end
      $display("Test second delay done");
      run(2'b00, 7'h00, 7'h00, 3'b000, 1'b0);
      stop();
      strength_ok <= 1'b1;
      run(2'b00, 7'h00, 7'h00, 3'b000, 1'b1);
      acc_off();
      @(posedge clk);
      msg_fail <= 1'b1;
      @(posedge clk);
      msg_fail <= 1'b0;
      #1;
      `CHK(wake_state, S_PERIOD)
      stop();
      $display("Test strength and message fail done");
      foreach (rt[i]) begin
         wr(1'b1, {14'h0, 2'b01, 1'b1, rt[i][0][9:0], rt[i][1][4:0]});
         run(2'b00, 7'h00, 7'h00, 3'b000, 1'b1);
         @(posedge clk);
         rx_data <= ~rx_data;
         repeat (rt[i][2] * UNIT) @(posedge clk);
         rx_data <= ~rx_data;
         wait_on(3, n);
         `CHK(header_accept, rt[i][3][0])
         `CHK(header_reject, ~rt[i][3][0])
         if (rt[i][3] == 0) begin
            @(posedge clk);
            #1;
            `CHK(wake_state, S_PERIOD)
         end
         stop();
      end
      $display("Test rate check done");
      for (int p = 0; p < 4; p++) begin
         wr(1'b1, {14'h0, p[1:0], 1'b0, 10'd63, 5'd8});
         @(posedge clk);
         #1;
         `CHK({seen, alert_pin_oe}, {1'b0, ~p[1]})
         run(2'b00, 7'h00, 7'h00, 3'b000, 1'b1);
         acc_off();
         @(posedge clk);
         msg_valid <= 1'b1;
         @(posedge clk);
         msg_valid <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         `CHK({seen, alert_pin_oe, alert_pin_out}, {2'b11, p == 1})
         `CHK({wuc_rdata[31], wake_state}, {1'b0, S_OFF})
         @(posedge clk);
         ack_en <= 1'b1;
         repeat (4) @(posedge clk);
         ack_en <= 1'b0;
         #1;
         `CHK(seen, 1'b0)
      end
      $display("Test polarity done");
      end_sim();
   end
endmodule : alert_output_pin_timing_rate_check_bench
